// [src/vector_map_pkg.sv]
// Purpose: Constants shared by the interrupt vector map.
// Assumes: Word addressed program memory, 14-bit program counter.
// Notes: Vector n sits at table base plus twice (n minus 1).
package vector_map_pkg;
  localparam int unsigned SRC_COUNT = 25;
  localparam int unsigned VEC_COUNT = 26;
  localparam int unsigned PC_W = 14;
  localparam int unsigned NUM_W = 5;
  localparam logic [13:0] RESET_APP_ADDR = 14'h0000;
  localparam logic [13:0] APP_TABLE_BASE = 14'h0000;
  localparam logic [13:0] BOOT_START_DEFAULT = 14'h1c00;
  localparam logic [13:0] VEC_STRIDE = 14'h0002;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  // Source indices; vector number is index plus two
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_EXT1 = 1;
  localparam int unsigned SRC_PCG0 = 2;
  localparam int unsigned SRC_PCG1 = 3;
  localparam int unsigned SRC_PCG2 = 4;
  localparam int unsigned SRC_WDOG = 5;
  localparam int unsigned SRC_TB8_MA = 6;
  localparam int unsigned SRC_TB8_MB = 7;
  localparam int unsigned SRC_TB8_WRAP = 8;
  localparam int unsigned SRC_TW16_CAP = 9;
  localparam int unsigned SRC_TW16_MA = 10;
  localparam int unsigned SRC_TW16_MB = 11;
  localparam int unsigned SRC_TW16_WRAP = 12;
  localparam int unsigned SRC_TA8_MA = 13;
  localparam int unsigned SRC_TA8_MB = 14;
  localparam int unsigned SRC_TA8_WRAP = 15;
  localparam int unsigned SRC_SPI_DONE = 16;
  localparam int unsigned SRC_SER_RX = 17;
  localparam int unsigned SRC_SER_TXE = 18;
  localparam int unsigned SRC_SER_TXD = 19;
  localparam int unsigned SRC_CONV = 20;
  localparam int unsigned SRC_NVM = 21;
  localparam int unsigned SRC_ACMP = 22;
  localparam int unsigned SRC_TWO_WIRE = 23;
  localparam int unsigned SRC_PSTORE = 24;
  localparam logic [4:0] VEC_NUM_RESET = 5'h01;
  localparam logic [4:0] VEC_NUM_FIRST_IRQ = 5'h02;
endpackage

// [src/vector_offset_rom.sv]
// Purpose: Registered lookup of a vector number's table offset.
// Assumes: Vector numbers 1 to 26; others read as zero.
// Notes: Offset is two words per entry, data leaves a register.
module vector_offset_rom (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [4:0] vec_num,
  output logic [13:0] offset
);
  logic [13:0] offset_d;
  logic [13:0] offset_q;

  // Offset is the vector number less one, times two
  always_comb
  begin
    offset_d = 14'h0000;
    if (vec_num != 5'h00 && vec_num <= 5'(vector_map_pkg::VEC_COUNT))
    begin
      offset_d = 14'(vec_num - vector_map_pkg::VEC_NUM_RESET)
        * vector_map_pkg::VEC_STRIDE;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      offset_q <= 14'h0000;
    else
      offset_q <= offset_d;
  end

  assign offset = offset_q;
endmodule

// [src/interrupt_vector_map.sv]
// Purpose: Picks the vector for a reset or the highest priority request.
// Assumes: Requests are levels held by the sources until serviced.
// Notes: Fuse and select bit come in as plain inputs; output is
//   registered, valid three cycles after a take strobe.
//   Takes in the two busy cycles after an accepted one are dropped.
//   A take_irq with nothing pending answers with vector_none only,
//   and the map stays free for the next take.
//   Pending levels are looked at on the take edge alone; fuse,
//   select and boot start are looked at two edges later.
//   Software must settle the select bit before any take_irq.
//   Boot start is a plain input that must not move during a take.

// Behaviour
// - System reset goes to vector one, at word zero while the boot fuse is unprogrammed.
// - External request zero at 0x0002, request one at 0x0004.
// - Pin change groups at 0x0006, 0x0008, 0x000A; watchdog at 0x000C.
// - Second 8-bit timer at 0x000E, 0x0010, 0x0012.
// - 16-bit timer capture, match a, match b, wrap at 0x0014 to 0x001A.
// - First 8-bit timer at 0x001C, 0x001E, 0x0020.
// - SPI at 0x0022; serial receive, buffer empty, transmit at 0x0024-28.
// - Converter, data nvm, comparator, two-wire, program store 0x002A-32.
// - Programmed boot fuse starts execution at the boot loader address.
// - Boot table at 0x1C00 for reset and 0x1C02 for first interrupt.
// - With select set, vectors are table offset plus boot start.
// - Fuse one means word zero reset; select clear puts vectors at 0x002.
module interrupt_vector_map (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [13:0] boot_start,
  input wire logic boot_reset_select_fuse,
  input wire logic vector_table_select_bit,
  input wire logic take_reset,
  input wire logic take_irq,
  input wire logic [24:0] irq_pending,
  output logic [13:0] vector_addr,
  output logic [4:0] vector_num,
  output logic vector_valid,
  output logic vector_none
);
  // Take, wait for the offset register, then form the address
  typedef enum logic [1:0] {IDLE, LOOKUP, FORM} phase_e;

  // All state of the map in one record
  typedef struct packed {
    phase_e phase;
    logic is_reset;
    logic [4:0] num;
    logic [13:0] addr;
    logic valid;
    logic none;
  } state_s;

  // State register and its next value
  state_s s_q;
  state_s s_d;

  // Priority pick, offset lookup and base selection
  wire [24:0] below_pend;
  wire [24:0] win_hot;
  logic [4:0] win_num;
  logic win_any;
  logic [13:0] rom_offset;
  logic [13:0] table_base;
  logic [13:0] reset_base;

  // lowest wins
  // A source wins only while no lower index is pending, so the
  // order of the table is the order of service
  for (genvar g = 0; g < vector_map_pkg::SRC_COUNT; g++)
  begin : g_pick
    if (g == 0)
    begin : g_first
      assign below_pend[g] = 1'b0; // Nothing lies below index zero
    end
    else
    begin : g_next
      assign below_pend[g] = below_pend[g-1] | irq_pending[g-1];
    end
    assign win_hot[g] = irq_pending[g] & ~below_pend[g];
  end

  // index zero is vector two
  // Encode the one-hot winner; bit i is vector i plus two
  always_comb
  begin
    win_num = 5'h00;
    for (int i = 0; i < vector_map_pkg::SRC_COUNT; i++)
    begin
      if (win_hot[i])
      begin
        win_num = 5'(i) + vector_map_pkg::VEC_NUM_FIRST_IRQ;
      end
    end
  end

  // Any pending level makes an interrupt take answerable
  assign win_any = |irq_pending;

  // two words each
  // The offset register adds one cycle; LOOKUP waits it out
  vector_offset_rom vector_offset_rom_i (
    .clock(clock),
    .rstn(rstn),
    .vec_num(s_q.num),
    .offset(rom_offset)
  );

  // Reset base follows the fuse alone, not the select bit
  // boot fuse relocation
  always_comb
  begin
    if (boot_reset_select_fuse == vector_map_pkg::FUSE_PROGRAMMED)
      reset_base = boot_start;
    else
      reset_base = vector_map_pkg::RESET_APP_ADDR;
  end

  // Table base follows the select bit alone, not the fuse
  // boot table base
  always_comb
  begin
    if (vector_table_select_bit)
      table_base = boot_start;
    else
      table_base = vector_map_pkg::APP_TABLE_BASE;
  end

  // Take, wait for the offset lookup, then form the address
  always_comb
  begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.none = 1'b0;
    unique case (s_q.phase)
      // Accept a take; a reset take beats an interrupt take
      IDLE:
      begin
        if (take_reset)
        begin
          s_d.is_reset = 1'b1;
          s_d.num = vector_map_pkg::VEC_NUM_RESET;
          s_d.phase = LOOKUP;
        end
        else if (take_irq)
        begin
          if (win_any)
          begin
            s_d.is_reset = 1'b0;
            s_d.num = win_num;
            s_d.phase = LOOKUP;
          end
          else
          begin
            s_d.none = 1'b1; // Nothing pending
          end
        end
      end
      // Takes seen here are ignored while the offset settles
      LOOKUP:
      begin
        s_d.phase = FORM;
      end
      // Fuse, select and boot start are sampled on this edge
      FORM:
      begin
        if (s_q.is_reset)
        begin
          s_d.addr = reset_base;
        end
        else
        begin
          s_d.addr = table_base + rom_offset;
        end
        s_d.valid = 1'b1;
        s_d.phase = IDLE;
      end
      // The fourth code of the phase is never entered
      default:
      begin
        s_d.phase = IDLE;
      end
    endcase
  end

  // Register the state; reset clears every field
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s_q.phase <= IDLE;
      s_q.is_reset <= 1'b0;
      s_q.num <= 5'h00;
      s_q.addr <= 14'h0000;
      s_q.valid <= 1'b0;
      s_q.none <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  // Outputs come straight from the state register
  assign vector_addr = s_q.addr;
  assign vector_num = s_q.num;
  assign vector_valid = s_q.valid;
  assign vector_none = s_q.none;
endmodule

// [verification/vector_map_chk.sv]
// Purpose: Port checks of the vector map.
// Assumes: Fuse, select and boot start steady during a take.
// Notes: Bound into every map instance.
module vector_map_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [13:0] boot_start,
  input wire logic boot_reset_select_fuse,
  input wire logic vector_table_select_bit,
  input wire logic take_reset,
  input wire logic take_irq,
  input wire logic [24:0] irq_pending,
  input wire logic [13:0] vector_addr,
  input wire logic [4:0] vector_num,
  input wire logic vector_valid,
  input wire logic vector_none
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] bz_q;
  wire acc = (take_reset | take_irq) && bz_q == 2'h0;
  wire irq = acc && !take_reset;
  // Busy window after a take that gets an answer; takes inside it
  // are ignored, a take with nothing pending leaves the map free
  always_ff @(posedge clock)
    bz_q <= !rstn ? 2'h0 : acc && (take_reset || |irq_pending) ? 2'h2
      : bz_q - 2'(bz_q != 2'h0);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_reset_num: assert property (acc && take_reset |=>
    vector_num == 5'h01) else $error("reset number");
  a_reset_addr: assert property (acc && take_reset |-> ##3 vector_valid
    && vector_addr == (boot_reset_select_fuse ? 14'h0000 : boot_start))
    else $error("reset address");
  a_low_wins: assert property (irq && |irq_pending |=>
    25'(1) << (vector_num - 5'h02) == $past(irq_pending & -irq_pending))
    else $error("priority");
  a_irq_addr: assert property (irq && |irq_pending |-> ##3 vector_valid
    && vector_addr == (vector_table_select_bit ? boot_start : 14'h0000)
    + {8'h00, vector_num, 1'b0} - 14'h0002) else $error("irq address");
  a_none_pulse: assert property (irq && !(|irq_pending) |=>
    vector_none ##1 !vector_none ##1 !vector_valid) else $error("none");
  a_valid_cause: assert property (vector_valid |-> $past(acc, 3))
    else $error("stray valid");
  a_valid_once: assert property (vector_valid |=> !vector_valid)
    else $error("valid width");
  a_addr_hold: assert property (!vector_valid |-> $stable(vector_addr))
    else $error("address moved");
  c_boot_reset: cover property (acc && take_reset && !boot_reset_select_fuse);
  c_boot_irq: cover property (vector_valid && vector_table_select_bit);
  c_none: cover property (vector_none);
endmodule
bind interrupt_vector_map vector_map_chk vector_map_chk_i (.*);

// [verification/core_model.sv]
// Purpose: Core side that fetches the vector word.
// Assumes: Fetch happens on the valid pulse.
// Notes: Keeps the last fetched address.
module core_model (
  input wire logic clock,
  input wire logic vector_valid,
  input wire logic [13:0] vector_addr,
  output logic [13:0] fetch_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Latch the address the core jumps to
  always_ff @(posedge clock)
    if (vector_valid)
      fetch_addr <= vector_addr;
endmodule

// [verification/tb_interrupt_vector_map.sv]
// Purpose: Self-checking bench of the vector map.
// Assumes: Boot section starts at word 0x1C00.
// Notes: One task per scenario.
module tb_interrupt_vector_map;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rstn, take_reset, take_irq, vector_valid, vector_none;
  logic boot_reset_select_fuse, vector_table_select_bit;
  logic [13:0] boot_start, vector_addr, fetch_addr;
  logic [24:0] irq_pending;
  logic [4:0] vector_num;
  int bad_count = 0;
  int cmp_count = 0;
  interrupt_vector_map interrupt_vector_map_i (.*);
  core_model core_model_i (.*);
  // Clock of 40 ns
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Take; for an interrupt take, poke a reset once while busy; then check number and fetched word
  task automatic take(input logic r, input logic [24:0] p,
      input logic [13:0] ea, input logic [4:0] en);
    int k;
    k = 0;
    take_reset <= r;
    take_irq <= 1'b1;
    irq_pending <= p;
    @(posedge clock);
    take_reset <= !r;
    take_irq <= 1'b0;
    do
    begin
      @(posedge clock);
      take_reset <= 1'b0;
      @(negedge clock);
    end
    while (vector_valid !== 1'b1 && ++k < 8);
    if (k == 8)
    begin
      bad_count++;
      final_report();
    end
    else
    begin
      chk({9'h000, vector_num}, {9'h000, en});
      @(negedge clock);
      chk(fetch_addr, ea);
      @(posedge clock);
    end
  endtask
  task automatic t_reset();
    for (int f = 0; f < 2; f++)
    begin
      boot_reset_select_fuse <= f[0];
      take(1'b1, 25'h000_0001, f ? 14'h0000 : 14'h1c00, 5'h01);
    end
  endtask
  task automatic t_sources();
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 25; i++)
      begin
        vector_table_select_bit <= s[0];
        take(1'b0, 25'(1) << i,
          (s ? 14'h1c00 : 14'h0000) + 14'(2 * i + 2), 5'(i + 2));
      end
  endtask
  task automatic t_prio();
    take(1'b0, 25'h100_0408, 14'h1c08, 5'h05);
    irq_pending <= 25'h000_0000;
    take_irq <= 1'b1;
    @(posedge clock);
    take_irq <= 1'b0;
    @(negedge clock);
    chk({13'h0000, vector_none}, 14'h0001);
    repeat (3) @(posedge clock);
    boot_reset_select_fuse <= 1'b0;
    take(1'b1, 25'h000_0000, 14'h1c00, 5'h01);
  endtask
  initial
  begin
    rstn = 1'b0;
    take_reset = 1'b0;
    take_irq = 1'b0;
    irq_pending = 25'h000_0000;
    boot_start = 14'h1c00;
    boot_reset_select_fuse = 1'b1;
    vector_table_select_bit = 1'b0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_sources();
    t_prio();
    final_report();
  end
endmodule
